// >>> design/spiu_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial unit
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are byte addresses on the APB side
`ifndef SPIU_MAP_SVH
`define SPIU_MAP_SVH
// ==========================================================
// Register map
`define SPIU_ADDR_W      8
`define SPIU_OFF_CTRL    8'h00
`define SPIU_OFF_DATA    8'h04
`define SPIU_OFF_STAT    8'h08
// ==========================================================
// Control register fields
`define SPIU_B_EN        0
`define SPIU_B_MST       1
`define SPIU_B_MODE_LO   2
`define SPIU_B_MODE_HI   3
`define SPIU_B_DONE      4
`define SPIU_B_MODE_FAULT_FLAG      5
`define SPIU_B_WRITE_COLLISION_FLAG      6
`define SPIU_B_OVR       7
// ==========================================================
// Status register fields
`define SPIU_B_BUSY      0
`define SPIU_B_TXFULL    1
`define SPIU_B_RXFULL    2
`define SPIU_B_NSS       3
// ==========================================================
// Select modes and reset values
`define SPIU_MODE_3W     2'h0
`define SPIU_MODE_4W_IN  2'h1
`define SPIU_MODE_RST    2'h1
`define SPIU_BYTE_RST    8'h00
`define SPIU_WORD_ZERO   32'h0000_0000
// ==========================================================
// Timing
`define SPIU_SYS_NS      40
`define SPIU_SCK_NS      320
`define SPIU_HALF        ((`SPIU_SCK_NS) / (2 * `SPIU_SYS_NS))
`define SPIU_LAST_BIT    3'h7
`define SPIU_CNT_ZERO    3'h0
// ==========================================================
// Pin index in the synchroniser vectors
`define SPIU_P_SCK       0
`define SPIU_P_MOSI      1
`define SPIU_P_MISO      2
`define SPIU_P_NSS       3
`endif

// >>> design/spiu_pkg.sv
// Purpose: Types shared by both ends of the serial link
// Assumes: Constants live in spiu_map.svh
// Notes:   One-hot clock generator states
package spiu_pkg;
  typedef enum logic [2:0] {
    SPIU_IDLE = 3'b001,
    SPIU_LOW  = 3'b010,
    SPIU_HIGH = 3'b100
  } spiu_st_t;
  typedef logic [1:0] spiu_mode_t;
endpackage

// >>> design/spiu_if.sv
// Purpose: Serial link wires between the unit and its far party
// Assumes: Each end gives value and enable for every pin it may drive
// Notes:   Undriven clock reads low, undriven select reads high
`timescale 1ns/1ps
interface spiu_if;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_mosi_o;
  logic dev_mosi_oe;
  logic dev_miso_o;
  logic dev_miso_oe;
  logic dev_nss_o;
  logic dev_nss_oe;
  logic peer_sck_o;
  logic peer_sck_oe;
  logic peer_mosi_o;
  logic peer_mosi_oe;
  logic peer_miso_o;
  logic peer_miso_oe;
  logic peer_nss_o;
  logic peer_nss_oe;
  logic sck;
  logic mosi;
  logic miso;
  logic nss;
  // ==========================================================
  // Wire resolution, the unit wins a clash
  assign sck  = dev_sck_oe  ? dev_sck_o  : (peer_sck_oe  ? peer_sck_o  : 1'b0);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (peer_mosi_oe ? peer_mosi_o : 1'b0);
  assign miso = dev_miso_oe ? dev_miso_o : (peer_miso_oe ? peer_miso_o : 1'b0);
  assign nss  = dev_nss_oe  ? dev_nss_o  : (peer_nss_oe  ? peer_nss_o  : 1'b1);
  modport dev (
    output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
    output dev_miso_o, dev_miso_oe, dev_nss_o, dev_nss_oe,
    input  sck, mosi, miso, nss
  );
  modport peer (
    output peer_sck_o, peer_sck_oe, peer_mosi_o, peer_mosi_oe,
    output peer_miso_o, peer_miso_oe, peer_nss_o, peer_nss_oe,
    input  sck, mosi, miso, nss
  );
endinterface

// >>> design/spiu_peer.sv
// Purpose: Far party of the link, a plain master or slave node
// Assumes: Clock phase 0, idle-low clock, tx_byte steady while a byte runs
// Notes:   Link inputs pass two flip-flops before use
`timescale 1ns/1ps
`include "spiu_map.svh"
module spiu_peer
  import spiu_pkg::*;
#(
  parameter int HALF = `SPIU_HALF
)(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       role_master,
  input  wire logic       use_nss,
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            busy,
  spiu_if.peer            link
);
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [7:0] sh_q;
  logic       inbit_q;
  logic [2:0] cnt_q;
  logic [7:0] div_q;
  spiu_st_t   st_q;
  logic       sel;
  logic       slv;
  logic       rise;
  logic       fall;
  logic       m_tick;
  logic       m_end;
  logic       samp;
  logic       din;
  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 4'h8;
      s2_q <= 4'h8;
      s3_q <= 4'h8;
    end else begin
      s1_q <= {link.nss, link.miso, link.mosi, link.sck};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign sel    = !use_nss || !s2_q[`SPIU_P_NSS];
  assign slv    = !role_master && sel;
  assign rise   = slv && s2_q[`SPIU_P_SCK] && !s3_q[`SPIU_P_SCK];
  assign fall   = slv && !s2_q[`SPIU_P_SCK] && s3_q[`SPIU_P_SCK];
  assign m_tick = div_q == 8'(HALF - 1);
  assign m_end  = st_q == SPIU_HIGH && m_tick;
  assign samp   = role_master ? m_end : rise;
  assign din    = role_master ? s2_q[`SPIU_P_MISO] : s2_q[`SPIU_P_MOSI];
  // ==========================================================
  // Clock generator, master role only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= SPIU_IDLE;
      div_q <= 8'h00;
    end else begin
      div_q <= (st_q == SPIU_IDLE || m_tick) ? 8'h00 : div_q + 8'h01;
      unique case (st_q)
        SPIU_IDLE: if (role_master && start) st_q <= SPIU_LOW;
        SPIU_LOW:  if (m_tick) st_q <= SPIU_HIGH;
        SPIU_HIGH: if (m_tick) st_q <= (cnt_q == `SPIU_LAST_BIT) ? SPIU_IDLE : SPIU_LOW;
      endcase
    end
  end
  // ==========================================================
  // Shift path, MSB first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh_q     <= `SPIU_BYTE_RST;
      inbit_q  <= 1'b0;
      cnt_q    <= `SPIU_CNT_ZERO;
      rx_byte  <= `SPIU_BYTE_RST;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (role_master && st_q == SPIU_IDLE) begin
        cnt_q <= `SPIU_CNT_ZERO;
        if (start) sh_q <= tx_byte;
      end else if (!role_master && !sel) begin
        cnt_q <= `SPIU_CNT_ZERO;
        sh_q  <= tx_byte;
      end else if (samp) begin
        cnt_q   <= cnt_q + 3'h1;
        inbit_q <= din;
        if (cnt_q == `SPIU_LAST_BIT) begin
          rx_byte  <= {sh_q[6:0], din};
          rx_valid <= 1'b1;
        end else if (role_master) begin
          sh_q <= {sh_q[6:0], din};
        end
      end else if (fall && cnt_q != `SPIU_CNT_ZERO) begin
        sh_q <= {sh_q[6:0], inbit_q};
      end else if (!role_master && cnt_q == `SPIU_CNT_ZERO && !s2_q[`SPIU_P_SCK]) begin
        sh_q <= tx_byte;
      end
    end
  end
  // ==========================================================
  // Pin drivers; slave use assumes it is the only slave on the bus
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.peer_sck_o   <= 1'b0;
      link.peer_sck_oe  <= 1'b0;
      link.peer_mosi_o  <= 1'b0;
      link.peer_mosi_oe <= 1'b0;
      link.peer_miso_o  <= 1'b0;
      link.peer_miso_oe <= 1'b0;
      link.peer_nss_o   <= 1'b1;
      link.peer_nss_oe  <= 1'b0;
      busy              <= 1'b0;
    end else begin
      link.peer_sck_o   <= st_q == SPIU_HIGH;
      link.peer_sck_oe  <= role_master;
      link.peer_mosi_o  <= sh_q[7];
      link.peer_mosi_oe <= role_master;
      link.peer_miso_o  <= sh_q[7];
      link.peer_miso_oe <= slv;
      link.peer_nss_o   <= st_q == SPIU_IDLE && !(role_master && start);
      link.peer_nss_oe  <= role_master && use_nss;
      busy              <= st_q != SPIU_IDLE || cnt_q != `SPIU_CNT_ZERO || (role_master && start);
    end
  end
endmodule

// >>> design/spiu_dev.sv
// Purpose: Serial peripheral unit, master or slave, 3-wire or 4-wire, APB registers
// Assumes: Clock phase 0, idle-low clock; link pins are asynchronous to clk_sys
// Notes:   Master samples its input at the end of the high phase to absorb sync delay
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "spiu_map.svh"
module spiu_dev
  import spiu_pkg::*;
#(
  parameter int AW   = `SPIU_ADDR_W,
  parameter int HALF = `SPIU_HALF
)(
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  spiu_if.dev                link
);
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic       en_q;
  logic       mst_q;
  spiu_mode_t mode_q;
  logic       done_q;
  logic       mode_fault_flag_q;
  logic       write_collision_flag_q;
  logic       ovr_q;
  logic [7:0] txbuf_q;
  logic       txfull_q;
  logic [7:0] sh_q;
  logic       shfull_q;
  logic [7:0] rxbuf_q;
  logic       rxfull_q;
  logic       inbit_q;
  logic [2:0] cnt_q;
  logic [7:0] div_q;
  spiu_st_t   st_q;
  logic       wr_ctrl;
  logic       wr_data;
  logic       rd_data;
  logic       sel;
  logic       slv;
  logic       nss_fall;
  logic       fault;
  logic       m_tick;
  logic       samp;
  logic       shft;
  logic       din;
  logic       done_ev;
  logic       load;
  logic       write_collision_flag_ev;
  logic       ovr_ev;
  logic       busy;

  function automatic logic spiu_hit(input logic [AW-1:0] a, input logic [7:0] off);
    spiu_hit = a == AW'(off);
  endfunction

  // ==========================================================
  // Pin synchronisers, third stage only for edge finding
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 4'h8;
      s2_q <= 4'h8;
      s3_q <= 4'h8;
    end else begin
      s1_q <= {link.nss, link.miso, link.mosi, link.sck};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // Decode and events
  assign wr_ctrl  = psel && penable && pready && pwrite && spiu_hit(paddr, `SPIU_OFF_CTRL);
  assign wr_data  = psel && penable && pready && pwrite && spiu_hit(paddr, `SPIU_OFF_DATA);
  assign rd_data  = psel && penable && pready && !pwrite && spiu_hit(paddr, `SPIU_OFF_DATA);
  assign nss_fall = !s2_q[`SPIU_P_NSS] && s3_q[`SPIU_P_NSS];
  assign sel      = mode_q != `SPIU_MODE_4W_IN || !s2_q[`SPIU_P_NSS];
  assign slv      = en_q && !mst_q && sel;
  assign fault    = en_q && mst_q && mode_q == `SPIU_MODE_4W_IN && nss_fall;
  assign m_tick   = div_q == 8'(HALF - 1);
  assign samp     = mst_q ? (st_q == SPIU_HIGH && m_tick) : (slv && s2_q[`SPIU_P_SCK] && !s3_q[`SPIU_P_SCK]);
  assign shft     = slv && !s2_q[`SPIU_P_SCK] && s3_q[`SPIU_P_SCK] && cnt_q != `SPIU_CNT_ZERO;
  assign din      = mst_q ? s2_q[`SPIU_P_MISO] : s2_q[`SPIU_P_MOSI];
  assign done_ev  = en_q && !fault && samp && cnt_q == `SPIU_LAST_BIT;
  assign load     = txfull_q && !shfull_q;
  assign write_collision_flag_ev  = wr_data && txfull_q;
  assign ovr_ev   = done_ev && !mst_q && rxfull_q && !rd_data;
  assign busy     = st_q != SPIU_IDLE || (slv && cnt_q != `SPIU_CNT_ZERO);

  // ==========================================================
  // Control bits; a fault overrides a same-cycle write of the enable and master bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_q   <= 1'b0;
      mst_q  <= 1'b0;
      mode_q <= `SPIU_MODE_RST;
    end else begin
      if (wr_ctrl) begin
        en_q   <= pwdata[`SPIU_B_EN];
        mst_q  <= pwdata[`SPIU_B_MST];
        mode_q <= pwdata[`SPIU_B_MODE_HI:`SPIU_B_MODE_LO];
      end
      if (fault) begin
        en_q  <= 1'b0;
        mst_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Sticky flags, write one to clear, set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      ovr_q  <= 1'b0;
    end else begin
      done_q <= done_ev || (done_q && !(wr_ctrl && pwdata[`SPIU_B_DONE]));
      mode_fault_flag_q <= fault || (mode_fault_flag_q && !(wr_ctrl && pwdata[`SPIU_B_MODE_FAULT_FLAG]));
      write_collision_flag_q <= write_collision_flag_ev || (write_collision_flag_q && !(wr_ctrl && pwdata[`SPIU_B_WRITE_COLLISION_FLAG]));
      ovr_q  <= ovr_ev || (ovr_q && !(wr_ctrl && pwdata[`SPIU_B_OVR]));
    end
  end

  // ==========================================================
  // Transmit and receive buffers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txbuf_q  <= `SPIU_BYTE_RST;
      txfull_q <= 1'b0;
      rxbuf_q  <= `SPIU_BYTE_RST;
      rxfull_q <= 1'b0;
    end else begin
      if (wr_data && !txfull_q) begin
        txbuf_q  <= pwdata[7:0];
        txfull_q <= 1'b1;
      end else if (load || !en_q) begin
        txfull_q <= 1'b0;
      end
      // Overrun keeps the unread byte; a master simply overwrites
      if (done_ev && !ovr_ev) begin
        rxbuf_q  <= {sh_q[6:0], din};
        rxfull_q <= 1'b1;
      end else if (rd_data) begin
        rxfull_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Master clock generator
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= SPIU_IDLE;
      div_q <= 8'h00;
    end else begin
      div_q <= (st_q == SPIU_IDLE || m_tick) ? 8'h00 : div_q + 8'h01;
      if (!en_q || !mst_q || fault) begin
        st_q <= SPIU_IDLE;
      end else begin
        unique case (st_q)
          SPIU_IDLE: if (shfull_q) st_q <= SPIU_LOW;
          SPIU_LOW:  if (m_tick) st_q <= SPIU_HIGH;
          SPIU_HIGH: if (m_tick) st_q <= (cnt_q == `SPIU_LAST_BIT) ? SPIU_IDLE : SPIU_LOW;
        endcase
      end
    end
  end

  // ==========================================================
  // Shift register and bit counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh_q     <= `SPIU_BYTE_RST;
      shfull_q <= 1'b0;
      inbit_q  <= 1'b0;
      cnt_q    <= `SPIU_CNT_ZERO;
    end else if (!en_q || fault) begin
      // Disabling is the only way to realign a 3-wire slave
      shfull_q <= 1'b0;
      cnt_q    <= `SPIU_CNT_ZERO;
    end else begin
      if (!mst_q && mode_q == `SPIU_MODE_4W_IN && nss_fall) begin
        cnt_q <= `SPIU_CNT_ZERO;
      end else if (mst_q && st_q == SPIU_IDLE) begin
        cnt_q <= `SPIU_CNT_ZERO;
      end else if (samp) begin
        cnt_q   <= cnt_q + 3'h1;
        inbit_q <= din;
      end
      if (done_ev) begin
        shfull_q <= 1'b0;
      end else if (load) begin
        sh_q     <= txbuf_q;
        shfull_q <= 1'b1;
      end else if (mst_q && samp) begin
        sh_q <= {sh_q[6:0], din};
      end else if (shft) begin
        sh_q <= {sh_q[6:0], inbit_q};
      end
    end
  end

  // ==========================================================
  // Pin drivers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.dev_sck_o   <= 1'b0;
      link.dev_sck_oe  <= 1'b0;
      link.dev_mosi_o  <= 1'b0;
      link.dev_mosi_oe <= 1'b0;
      link.dev_miso_o  <= 1'b0;
      link.dev_miso_oe <= 1'b0;
      link.dev_nss_o   <= 1'b1;
      link.dev_nss_oe  <= 1'b0;
    end else begin
      link.dev_sck_o   <= st_q == SPIU_HIGH;
      link.dev_sck_oe  <= en_q && mst_q && !fault;
      link.dev_mosi_o  <= sh_q[7];
      link.dev_mosi_oe <= en_q && mst_q && !fault;
      link.dev_miso_o  <= sh_q[7];
      link.dev_miso_oe <= slv;
      link.dev_nss_o   <= mode_q[0];
      link.dev_nss_oe  <= mode_q[1];
    end
  end

  // ==========================================================
  // APB slave, one wait state, unmapped offsets answer with an error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `SPIU_WORD_ZERO;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !(spiu_hit(paddr, `SPIU_OFF_CTRL)
                 || spiu_hit(paddr, `SPIU_OFF_DATA) || spiu_hit(paddr, `SPIU_OFF_STAT));
      prdata  <= `SPIU_WORD_ZERO;
      if (psel && penable && !pready && !pwrite) begin
        if (spiu_hit(paddr, `SPIU_OFF_CTRL)) begin
          prdata[`SPIU_B_EN]                      <= en_q;
          prdata[`SPIU_B_MST]                     <= mst_q;
          prdata[`SPIU_B_MODE_HI:`SPIU_B_MODE_LO] <= mode_q;
          prdata[`SPIU_B_DONE]                    <= done_q;
          prdata[`SPIU_B_MODE_FAULT_FLAG]                    <= mode_fault_flag_q;
          prdata[`SPIU_B_WRITE_COLLISION_FLAG]                    <= write_collision_flag_q;
          prdata[`SPIU_B_OVR]                     <= ovr_q;
        end else if (spiu_hit(paddr, `SPIU_OFF_DATA)) begin
          prdata[7:0] <= rxbuf_q;
        end else if (spiu_hit(paddr, `SPIU_OFF_STAT)) begin
          prdata[`SPIU_B_BUSY]   <= busy;
          prdata[`SPIU_B_TXFULL] <= txfull_q;
          prdata[`SPIU_B_RXFULL] <= rxfull_q;
          prdata[`SPIU_B_NSS]    <= s2_q[`SPIU_P_NSS];
        end
      end
    end
  end
endmodule

// >>> verification/spiu_chk.sv
// Purpose: Concurrent checks on the link between the unit and its far party
// Assumes: Clock phase 0, idle-low clock, HALF system cycles per clock phase
// Notes:   Sees only interface signals; phase checks skip aborted bytes
`timescale 1ns/1ps
module spiu_chk #(
  parameter int HALF = 4
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dev_sck_o,
  input wire logic dev_sck_oe,
  input wire logic dev_mosi_o,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_o,
  input wire logic dev_miso_oe,
  input wire logic dev_nss_oe,
  input wire logic peer_sck_o,
  input wire logic peer_sck_oe,
  input wire logic peer_mosi_o,
  input wire logic peer_nss_oe,
  input wire logic sck,
  input wire logic nss
);
  // ==========================================================
  // Phase length counters, saturating so a long idle cannot wrap
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= 8'h00;
      lo_q <= 8'h00;
    end else begin
      hi_q <= dev_sck_o ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00;
      lo_q <= dev_sck_o ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_master_pins: assert property (dev_sck_oe |-> dev_mosi_oe && !dev_miso_oe)
    else $error("clock driven without master pin set");
  a_slave_pins: assert property (dev_miso_oe |-> !dev_sck_oe && !dev_mosi_oe)
    else $error("slave output with master pins driven");
  a_sck_high_len: assert property ($fell(dev_sck_o) && dev_sck_oe && $past(dev_sck_oe) && nss
    |-> hi_q == 8'(HALF)) else $error("clock high phase length wrong");
  a_sck_low_len: assert property ($rose(dev_sck_o) && dev_sck_oe |-> lo_q >= 8'(HALF))
    else $error("clock low phase too short");
  a_mosi_hold_high: assert property (dev_sck_oe && dev_sck_o && $past(dev_sck_o) && nss
    |-> $stable(dev_mosi_o)) else $error("master data moved while clock high");
  a_peer_mosi_hold: assert property (peer_sck_oe && peer_sck_o && $past(peer_sck_o)
    |-> $stable(peer_mosi_o)) else $error("peer data moved while clock high");
  a_miso_hold_high: assert property (dev_miso_oe && $past(dev_miso_oe) && sck && $past(sck)
    && $past(sck, 2) |-> $stable(dev_miso_o)) else $error("slave data moved while clock high");
  a_fault_release: assert property ($fell(nss) && dev_sck_oe && !dev_nss_oe
    |-> ##[1:6] !dev_sck_oe) else $error("master kept clock after select fall");
  a_peer_sel_lead: assert property ($fell(nss) && peer_nss_oe |-> !peer_sck_o [*2])
    else $error("select fell too close to clock rise");
  // ==========================================================
  // Coverage
  c_master: cover property ($rose(dev_sck_oe));
  c_slave: cover property ($rose(dev_miso_oe));
  c_fault: cover property ($fell(nss) && dev_sck_oe);
  c_selout: cover property ($rose(dev_nss_oe));
endmodule

// >>> verification/tb_spi_pin_and_select_logic.sv
// Purpose: Self-checking bench, unit and far party joined by the link
// Assumes: APB answers after one wait state; far party HALF matches the unit
// Notes:   Far party is reconfigured per scenario; flags cleared on every control write
`timescale 1ns/1ps
`include "spiu_map.svh"
module tb_spi_pin_and_select_logic;
  localparam int HALF = 4;
  logic        clk_sys;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        role_master;
  logic        use_nss;
  logic        start;
  logic [7:0]  tx_byte;
  logic [7:0]  rx_byte;
  logic        rx_valid;
  logic        busy;
  logic [7:0]  peer_got;
  logic [15:0] mosi_sh;
  logic [15:0] miso_sh;
  logic [31:0] rd;
  logic        err;
  int          failures;
  int          total_checks;
  // ==========================================================
  // Design and checker
  spiu_if link();
  spiu_dev #(.HALF(HALF)) u_spiu_dev (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  spiu_peer #(.HALF(HALF)) u_spiu_peer (.clk_sys(clk_sys), .rst_n(rst_n), .role_master(role_master),
    .use_nss(use_nss), .start(start), .tx_byte(tx_byte), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .busy(busy), .link(link));
  spiu_chk #(.HALF(HALF)) u_spiu_chk (.clk_sys(clk_sys), .rst_n(rst_n), .dev_sck_o(link.dev_sck_o),
    .dev_sck_oe(link.dev_sck_oe), .dev_mosi_o(link.dev_mosi_o), .dev_mosi_oe(link.dev_mosi_oe),
    .dev_miso_o(link.dev_miso_o), .dev_miso_oe(link.dev_miso_oe), .dev_nss_oe(link.dev_nss_oe),
    .peer_sck_o(link.peer_sck_o), .peer_sck_oe(link.peer_sck_oe), .peer_mosi_o(link.peer_mosi_o),
    .peer_nss_oe(link.peer_nss_oe), .sck(link.sck), .nss(link.nss));
  // ==========================================================
  // Clock and wire monitors
  always #20 clk_sys = ~clk_sys;
  always @(posedge link.sck) begin
    mosi_sh <= {mosi_sh[14:0], link.mosi};
    miso_sh <= {miso_sh[14:0], link.miso};
  end
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      peer_got <= rx_byte;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic peer_xfer(input logic ns, input logic [7:0] b);
    int n;
    @(posedge clk_sys);
    role_master <= 1'b1;
    use_nss <= ns;
    tx_byte <= b;
    repeat (2) @(posedge clk_sys);
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((busy === 1'b1 || n < 3) && n < 300);
    if (n >= 300) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `SPIU_OFF_STAT, 32'h0000_0000);
      n++;
    end while (rd[1:0] !== 2'b00 && n < 80);
    if (n >= 80) begin
      failures++;
      finish_test();
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_reset;
    apb(1'b0, `SPIU_OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    apb(1'b0, `SPIU_OFF_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    chk({31'h0, link.dev_miso_oe}, 32'h0);
    chk({31'h0, link.dev_sck_oe}, 32'h0);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
  endtask
  // Three bytes written back to back: one shifts, one waits, one collides
  task automatic s_master3w;
    role_master <= 1'b0;
    use_nss <= 1'b0;
    tx_byte <= 8'h3C;
    apb(1'b1, `SPIU_OFF_CTRL, 32'h0000_00F3);
    mosi_sh <= 16'h0000;
    miso_sh <= 16'h0000;
    apb(1'b1, `SPIU_OFF_DATA, 32'h0000_00A5);
    apb(1'b1, `SPIU_OFF_DATA, 32'h0000_00C3);
    apb(1'b1, `SPIU_OFF_DATA, 32'h0000_007E);
    wait_idle();
    repeat (HALF) @(posedge clk_sys);
    chk({16'h0, mosi_sh}, 32'h0000_A5C3);
    chk({16'h0, miso_sh}, 32'h0000_3C3C);
    chk({24'h0, peer_got}, 32'h0000_00C3);
    chk({31'h0, link.dev_nss_oe}, 32'h0);
    apb(1'b0, `SPIU_OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0053);
    apb(1'b0, `SPIU_OFF_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_003C);
  endtask
  task automatic s_slave4w;
    apb(1'b1, `SPIU_OFF_CTRL, 32'h0000_00F5);
    apb(1'b1, `SPIU_OFF_DATA, 32'h0000_0096);
    chk({31'h0, link.dev_miso_oe}, 32'h0);
    peer_xfer(1'b0, 8'h11);
    chk({24'h0, peer_got}, 32'h0000_0000);
    apb(1'b0, `SPIU_OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    miso_sh <= 16'h0000;
    peer_xfer(1'b1, 8'h69);
    chk({24'h0, miso_sh[7:0]}, 32'h0000_0096);
    chk({24'h0, peer_got}, 32'h0000_0096);
    apb(1'b0, `SPIU_OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0015);
    apb(1'b0, `SPIU_OFF_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_0069);
  endtask
  task automatic s_slave3w;
    apb(1'b1, `SPIU_OFF_CTRL, 32'h0000_00F0);
    apb(1'b1, `SPIU_OFF_CTRL, 32'h0000_00F1);
    // Pin enables follow the control bits one cycle later
    repeat (2) @(posedge clk_sys);
    chk({31'h0, link.dev_miso_oe}, 32'h1);
    apb(1'b1, `SPIU_OFF_DATA, 32'h0000_0081);
    peer_xfer(1'b0, 8'h42);
    chk({24'h0, peer_got}, 32'h0000_0081);
    apb(1'b0, `SPIU_OFF_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_0042);
  endtask
  task automatic s_selout;
    apb(1'b1, `SPIU_OFF_CTRL, 32'h0000_00FB);
    repeat (2) @(posedge clk_sys);
    chk({30'h0, link.dev_nss_oe, link.nss}, 32'h2);
    apb(1'b1, `SPIU_OFF_CTRL, 32'h0000_00FF);
    repeat (2) @(posedge clk_sys);
    chk({30'h0, link.dev_nss_oe, link.nss}, 32'h3);
  endtask
  // Far master claims the bus in mid-byte
  task automatic s_fault;
    apb(1'b1, `SPIU_OFF_CTRL, 32'h0000_00F7);
    apb(1'b1, `SPIU_OFF_DATA, 32'h0000_0055);
    peer_xfer(1'b1, 8'h00);
    apb(1'b0, `SPIU_OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0024);
    chk({31'h0, link.dev_sck_oe}, 32'h0);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    role_master = 1'b0;
    use_nss = 1'b0;
    start = 1'b0;
    tx_byte = 8'h00;
    peer_got = 8'h00;
    mosi_sh = 16'h0000;
    miso_sh = 16'h0000;
    failures = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_reset();
    s_master3w();
    s_slave4w();
    s_slave3w();
    s_selout();
    s_fault();
    finish_test();
  end
endmodule
